// ==== hdl/fsp_apb_slave.sv ====
// APB slave with one wait state feeding the register carrier
`timescale 1ns/1ps
`default_nettype none
module fsp_apb_slave (
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rstn_in,
   // APB
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic             pready_out,
   output logic             pslverr_out,
   output logic [31:0]      prdata_out,
   // Core side
   fsp_reg_if.bus_side      regs
);
   logic        ready_reg; // Second access cycle marker
   logic        err_reg;   // Unmapped address seen
   logic        acc;       // In access phase
   assign acc = psel_in & penable_in;
   // Reads take effect at first access edge, writes on completion
   assign regs.rd_stb = acc & ~ready_reg & ~pwrite_in;
   assign regs.wr_stb = acc & ready_reg & pwrite_in;
   assign regs.addr   = paddr_in;
   assign regs.wdata  = pwdata_in;
   assign pready_out  = ready_reg;
   assign pslverr_out = ready_reg & err_reg;
   // Wait-state sequencer and error capture
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ready_reg <= 1'b0;
         err_reg   <= 1'b0;
      end else begin
         ready_reg <= acc & ~ready_reg;
         err_reg   <= ~regs.hit;
      end
   end
   // Read data held in a flop so the master sees stable data
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prdata_out <= 32'h0000_0000;
      end else if (regs.rd_stb) begin
         prdata_out <= regs.hit ? regs.rdata : 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// ==== hdl/fsp_ctrl.sv ====
// Fast interrupt, protect mode, spurious and general mask logic
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl #(
   parameter int SRC_W = 5 // Source number width
) (
   // Clock and reset
   input  wire logic             ref_clk_in,
   input  wire logic             rstn_in,
   // APB slave
   input  wire logic             psel_in,
   input  wire logic             penable_in,
   input  wire logic             pwrite_in,
   input  wire logic [11:0]      paddr_in,
   input  wire logic [31:0]      pwdata_in,
   output logic                  pready_out,
   output logic                  pslverr_out,
   output logic [31:0]           prdata_out,
   // Fast source pin
   input  wire logic             fast_src_in,
   // From priority controller
   input  wire logic             prio_irq_in,
   input  wire logic             prio_pending_in,
   input  wire logic [SRC_W-1:0] prio_src_in,
   input  wire logic [31:0]      prio_vector_in,
   input  wire logic [SRC_W-1:0] pop_src_in,
   // To priority controller and stack
   output logic                  push_stb_out,
   output logic                  push_spur_out,
   output logic [SRC_W-1:0]      push_src_out,
   output logic                  pop_stb_out,
   // To processor core
   output logic                  fast_request_n_out,
   output logic                  normal_request_n_out,
   output logic                  wake_out
);
   // Register carrier between slave and core
   fsp_reg_if regs ();

   // Programmable state
   logic [6:0]       source_zero_mode_reg;   // Priority and trigger
   logic [31:0]      source_zero_vector_reg; // Fast handler address
   logic [31:0]      spurious_vector_reg;    // Spurious handler
   logic [1:0]       debug_control_reg;      // Protect and mask
   logic             fast_en_reg;            // Fast source enable
   logic [SRC_W-1:0] cur_src_reg;            // Current source id
   // Protect-mode memory of the last vector read
   logic [SRC_W-1:0] held_src_reg;
   logic             held_spur_reg;
   // Trigger outputs
   logic             fast_pend;   // Fast source latched
   logic             fast_edge;   // Edge trigger selected
   logic             fast_active; // Pending and enabled
   // Decoded accesses
   logic             protect;
   logic             gmask;
   logic             rd_ivr;
   logic             rd_fvr;
   logic             wr_ivr;
   logic             wr_eoi;
   logic             fvr_clear;

   // Bus slave
   fsp_apb_slave u_slave (
      .ref_clk_in  (ref_clk_in),
      .rstn_in     (rstn_in),
      .psel_in     (psel_in),
      .penable_in  (penable_in),
      .pwrite_in   (pwrite_in),
      .paddr_in    (paddr_in),
      .pwdata_in   (pwdata_in),
      .pready_out  (pready_out),
      .pslverr_out (pslverr_out),
      .prdata_out  (prdata_out),
      .regs        (regs.bus_side)
   );

   // Fast source detector
   fsp_trigger u_trig (
      .ref_clk_in  (ref_clk_in),
      .rstn_in     (rstn_in),
      .src_pin_in  (fast_src_in),
      .trig_in     (source_zero_mode_reg[fsp_pkg::TRIG_LSB +: 2]),
      .clear_in    (fvr_clear),
      .pending_out (fast_pend),
      .is_edge_out (fast_edge)
   );

   // Named control bits
   assign protect = debug_control_reg[fsp_pkg::PROTECT_B];
   assign gmask   = debug_control_reg[fsp_pkg::GMASK_B];
   assign fast_active = fast_pend & fast_en_reg;

   // Address match helper
   function automatic logic at(input logic [11:0] a,
                               input logic [11:0] ofs);
      at = (a == ofs);
   endfunction

   // Side-effect strobes
   assign rd_ivr = regs.rd_stb & at(regs.addr, fsp_pkg::IVR_OFS);
   assign rd_fvr = regs.rd_stb & at(regs.addr, fsp_pkg::FVR_OFS);
   assign wr_ivr = regs.wr_stb & at(regs.addr, fsp_pkg::IVR_OFS);
   assign wr_eoi = regs.wr_stb & at(regs.addr, fsp_pkg::EOICR_OFS);
   // Level sources are not touched by a vector read
   assign fvr_clear = rd_fvr & fast_edge;

   // Address decode: which offsets answer without error
   always_comb begin
      case (regs.addr)
         fsp_pkg::SMR0_OFS,
         fsp_pkg::SVR0_OFS,
         fsp_pkg::IVR_OFS,
         fsp_pkg::FVR_OFS,
         fsp_pkg::ISR_OFS,
         fsp_pkg::IMR_OFS,
         fsp_pkg::IECR_OFS,
         fsp_pkg::IDCR_OFS,
         fsp_pkg::EOICR_OFS,
         fsp_pkg::SPU_OFS,
         fsp_pkg::DCR_OFS: regs.hit = 1'b1;
         default:          regs.hit = 1'b0;
      endcase
   end

   // Read multiplexer; write-only registers read as zero
   always_comb begin
      regs.rdata = 32'h0000_0000;
      case (regs.addr)
         fsp_pkg::SMR0_OFS:
            regs.rdata = {25'h0, source_zero_mode_reg};
         fsp_pkg::SVR0_OFS:
            regs.rdata = source_zero_vector_reg;
         fsp_pkg::IVR_OFS: begin
            // Pending source vector, else spurious
            if (prio_pending_in) begin
               regs.rdata = prio_vector_in;
            end else begin
               regs.rdata = spurious_vector_reg;
            end
         end
         fsp_pkg::FVR_OFS: begin
            if (fast_active) begin
               regs.rdata = source_zero_vector_reg;
            end else begin
               regs.rdata = spurious_vector_reg;
            end
         end
         fsp_pkg::ISR_OFS:
            regs.rdata = {{(32-SRC_W){1'b0}}, cur_src_reg};
         fsp_pkg::IMR_OFS:
            regs.rdata = {31'h0, fast_en_reg};
         fsp_pkg::SPU_OFS:
            regs.rdata = spurious_vector_reg;
         fsp_pkg::DCR_OFS:
            regs.rdata = {30'h0, debug_control_reg};
         default:
            regs.rdata = 32'h0000_0000;
      endcase
   end

   // Source-zero mode: priority kept only for read-back
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         source_zero_mode_reg <= fsp_pkg::SMR_RST;
      end else if (regs.wr_stb & at(regs.addr, fsp_pkg::SMR0_OFS)) begin
         // Bits 4:3 are unused and stay zero
         source_zero_mode_reg <= {regs.wdata[6:5], 2'b00,
                                  regs.wdata[2:0]};
      end
   end

   // Vector registers
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         source_zero_vector_reg <= fsp_pkg::VEC_RST;
         spurious_vector_reg    <= fsp_pkg::VEC_RST;
      end else if (regs.wr_stb) begin
         if (at(regs.addr, fsp_pkg::SVR0_OFS)) begin
            source_zero_vector_reg <= regs.wdata;
         end
         if (at(regs.addr, fsp_pkg::SPU_OFS)) begin
            spurious_vector_reg <= regs.wdata;
         end
      end
   end

   // Debug control: protect mode and general mask
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         debug_control_reg <= fsp_pkg::DCR_RST;
      end else if (regs.wr_stb & at(regs.addr, fsp_pkg::DCR_OFS)) begin
         debug_control_reg <= regs.wdata[1:0];
      end
   end

   // Fast enable; only bit 0 matters in either command
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         fast_en_reg <= 1'b0;
      end else if (regs.wr_stb & regs.wdata[fsp_pkg::FAST_EN_B]) begin
         if (at(regs.addr, fsp_pkg::IECR_OFS)) begin
            fast_en_reg <= 1'b1;
         end else if (at(regs.addr, fsp_pkg::IDCR_OFS)) begin
            fast_en_reg <= 1'b0;
         end
      end
   end

   // Protect mode memorises what the read found
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         held_src_reg  <= fsp_pkg::ISR_RST;
         held_spur_reg <= 1'b1;
      end else if (rd_ivr & protect) begin
         // Repeated reads only refresh the memo
         held_src_reg  <= prio_src_in;
         held_spur_reg <= ~prio_pending_in;
      end
   end

   // Push and acknowledge toward the stack, one-cycle pulses
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         push_stb_out  <= 1'b0;
         push_spur_out <= 1'b0;
         push_src_out  <= fsp_pkg::ISR_RST;
      end else begin
         push_stb_out <= 1'b0;
         if (rd_ivr & ~protect) begin
            // Normal mode: read does it all, even when spurious
            push_stb_out  <= 1'b1;
            push_spur_out <= ~prio_pending_in;
            push_src_out  <= prio_src_in;
         end else if (wr_ivr & protect) begin
            // Protect mode: the write does the stacking
            push_stb_out  <= 1'b1;
            push_spur_out <= held_spur_reg;
            push_src_out  <= held_src_reg;
         end
         // Normal mode write to the vector falls through
      end
   end

   // Current source id as seen in the status register
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cur_src_reg <= fsp_pkg::ISR_RST;
      end else if (wr_eoi) begin
         cur_src_reg <= pop_src_in;
      end else if (rd_ivr & ~protect & prio_pending_in) begin
         cur_src_reg <= prio_src_in;
      end else if (wr_ivr & protect & ~held_spur_reg) begin
         cur_src_reg <= held_src_reg;
      end
   end

   // End of service pops the level stack outside
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pop_stb_out <= 1'b0;
      end else begin
         pop_stb_out <= wr_eoi;
      end
   end

   // Request lines, held inactive high under the general mask;
   // registered so no glitch reaches the core
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         fast_request_n_out   <= 1'b1;
         normal_request_n_out <= 1'b1;
      end else begin
         fast_request_n_out   <= ~(fast_active & ~gmask);
         normal_request_n_out <= ~(prio_irq_in & ~gmask);
      end
   end

   // Wake-up ignores the general mask on purpose
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wake_out <= 1'b0;
      end else begin
         wake_out <= fast_active | prio_irq_in;
      end
   end
endmodule
`default_nettype wire

// ==== hdl/fsp_pkg.sv ====
// Shared constants and types for the fast/protect/spurious block
package fsp_pkg;
   // Register byte offsets inside the 4 KB window
   localparam logic [11:0] SMR0_OFS  = 12'h000;
   localparam logic [11:0] SVR0_OFS  = 12'h080;
   localparam logic [11:0] IVR_OFS   = 12'h100;
   localparam logic [11:0] FVR_OFS   = 12'h104;
   localparam logic [11:0] ISR_OFS   = 12'h108;
   localparam logic [11:0] IMR_OFS   = 12'h110;
   localparam logic [11:0] IECR_OFS  = 12'h120;
   localparam logic [11:0] IDCR_OFS  = 12'h124;
   localparam logic [11:0] EOICR_OFS = 12'h130;
   localparam logic [11:0] SPU_OFS   = 12'h134;
   localparam logic [11:0] DCR_OFS   = 12'h138;
   // Field positions
   localparam int PRIO_LSB   = 0;
   localparam int PRIO_W     = 3;
   localparam int TRIG_LSB   = 5;
   localparam int TRIG_W     = 2;
   localparam int PROTECT_B  = 0;
   localparam int GMASK_B    = 1;
   localparam int FAST_EN_B  = 0;
   localparam int SRC_W      = 5;
   // Reset values
   localparam logic [31:0] VEC_RST = 32'h0000_0000;
   localparam logic [6:0]  SMR_RST = 7'h00;
   localparam logic [1:0]  DCR_RST = 2'h0;
   localparam logic [4:0]  ISR_RST = 5'h00;
   // Trigger type of the fast source
   typedef enum logic [1:0] {
      FSP_LOW_LEVEL = 2'b00,
      FSP_FALL_EDGE = 2'b01,
      FSP_HIGH_LEVEL = 2'b10,
      FSP_RISE_EDGE = 2'b11
   } fsp_trig_t;
endpackage

// ==== hdl/fsp_reg_if.sv ====
// Register access carrier between bus slave and core logic
`timescale 1ns/1ps
`default_nettype none
interface fsp_reg_if;
   logic [11:0] addr;   // Byte address of access
   logic [31:0] wdata;  // Write data
   logic        rd_stb; // One-cycle read strobe
   logic        wr_stb; // One-cycle write strobe
   logic [31:0] rdata;  // Read value, combinational
   logic        hit;    // Address is mapped
   modport bus_side (output addr, wdata, rd_stb, wr_stb,
                     input rdata, hit);
   modport core_side (input addr, wdata, rd_stb, wr_stb,
                      output rdata, hit);
endinterface
`default_nettype wire

// ==== hdl/fsp_trigger.sv ====
// Fast source synchroniser and edge/level detector
`timescale 1ns/1ps
`default_nettype none
module fsp_trigger (
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rstn_in,
   // Source and control
   input  wire logic        src_pin_in,
   input  wire logic [1:0]  trig_in,
   input  wire logic        clear_in,
   // Result
   output logic             pending_out,
   output logic             is_edge_out
);
   logic s1_reg;   // First sync stage, read only by s2
   logic s2_reg;   // Second sync stage
   logic prev_reg; // Previous synced value
   logic edge_hit;
   fsp_pkg::fsp_trig_t trig;
   assign trig = fsp_pkg::fsp_trig_t'(trig_in);
   // Double-flop the pin before any logic sees it;
   // reset to the idle level of the low-level default
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s1_reg   <= 1'b1;
         s2_reg   <= 1'b1;
         prev_reg <= 1'b1;
      end else begin
         s1_reg   <= src_pin_in;
         s2_reg   <= s1_reg;
         prev_reg <= s2_reg;
      end
   end
   // Detect the two edge trigger types; level types give no edge
   always_comb begin
      case (trig)
         fsp_pkg::FSP_FALL_EDGE: edge_hit = prev_reg & ~s2_reg;
         fsp_pkg::FSP_RISE_EDGE: edge_hit = ~prev_reg & s2_reg;
         default:                edge_hit = 1'b0;
      endcase
   end
   assign is_edge_out = trig_in[0];
   // Edge latch: new edge wins over clear; level follows the pin
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pending_out <= 1'b0;
      end else begin
         case (trig)
            fsp_pkg::FSP_LOW_LEVEL:  pending_out <= ~s2_reg;
            fsp_pkg::FSP_HIGH_LEVEL: pending_out <= s2_reg;
            default: begin
               if (edge_hit) begin
                  pending_out <= 1'b1;
               end else if (clear_in) begin
                  pending_out <= 1'b0;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== verification/fsp_ctrl_chk.sv ====
// Assertion checker for the fast/protect/spurious controller
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl_chk #(
   parameter int SRC_W = 5 // Source number width
) (
   // Clock, reset and bus
   input wire logic             ref_clk_in,
   input wire logic             rstn_in,
   input wire logic             psel_in,
   input wire logic             penable_in,
   input wire logic             pwrite_in,
   input wire logic [11:0]      paddr_in,
   input wire logic [31:0]      pwdata_in,
   input wire logic             pready_out,
   // Priority side and request lines
   input wire logic             prio_pending_in,
   input wire logic [SRC_W-1:0] prio_src_in,
   input wire logic             push_stb_out,
   input wire logic             push_spur_out,
   input wire logic [SRC_W-1:0] push_src_out,
   input wire logic             pop_stb_out,
   input wire logic             fast_request_n_out,
   input wire logic             normal_request_n_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   logic rd1;    // First access edge of a read
   logic wr_e;   // Edge at which a write lands
   logic ivr_r;  // Vector read side effects
   logic ivr_w;  // Vector write lands
   logic eoi_w;  // End of service write lands
   logic prot_q; // Protect mode as last written
   logic gm_q;   // General mask as last written
   assign rd1 = psel_in && penable_in && !pready_out && !pwrite_in;
   assign wr_e = psel_in && penable_in && pready_out && pwrite_in;
   assign ivr_r = rd1 && paddr_in == fsp_pkg::IVR_OFS;
   assign ivr_w = wr_e && paddr_in == fsp_pkg::IVR_OFS;
   assign eoi_w = wr_e && paddr_in == fsp_pkg::EOICR_OFS;
   // Mirror of debug control, so modes need no peek inside
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prot_q <= 1'b0;
         gm_q   <= 1'b0;
      end else if (wr_e && paddr_in == fsp_pkg::DCR_OFS) begin
         prot_q <= pwdata_in[fsp_pkg::PROTECT_B];
         gm_q   <= pwdata_in[fsp_pkg::GMASK_B];
      end
   end
   property p_gmask;
      gm_q && $past(gm_q) |-> fast_request_n_out && normal_request_n_out;
   endproperty
   a_gmask: assert property (p_gmask) else $error("request under mask");
   property p_nrd;
      ivr_r && !prot_q |=> push_stb_out;
   endproperty
   a_nrd: assert property (p_nrd) else $error("no push on read");
   property p_psrc;
      ivr_r && !prot_q && prio_pending_in
         |=> push_src_out == $past(prio_src_in) && !push_spur_out;
   endproperty
   a_psrc: assert property (p_psrc) else $error("wrong pushed id");
   property p_spur;
      ivr_r && !prot_q && !prio_pending_in |=> push_stb_out && push_spur_out;
   endproperty
   a_spur: assert property (p_spur) else $error("spurious not flagged");
   property p_prd;
      ivr_r && prot_q |=> !push_stb_out [*2];
   endproperty
   a_prd: assert property (p_prd) else $error("push on protect read");
   property p_pwr;
      ivr_w && prot_q |=> push_stb_out;
   endproperty
   a_pwr: assert property (p_pwr) else $error("no push on write");
   property p_nwr;
      ivr_w && !prot_q |=> !push_stb_out;
   endproperty
   a_nwr: assert property (p_nwr) else $error("normal write acted");
   property p_eoi;
      eoi_w |=> pop_stb_out;
   endproperty
   a_eoi: assert property (p_eoi) else $error("no pop");
   property p_popc;
      pop_stb_out |-> $past(eoi_w);
   endproperty
   a_popc: assert property (p_popc) else $error("pop without cause");
endmodule
bind fsp_ctrl fsp_ctrl_chk #(.SRC_W(SRC_W)) chk_u (
   .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .pready_out(pready_out),
   .prio_pending_in(prio_pending_in), .prio_src_in(prio_src_in),
   .push_stb_out(push_stb_out), .push_spur_out(push_spur_out),
   .push_src_out(push_src_out), .pop_stb_out(pop_stb_out),
   .fast_request_n_out(fast_request_n_out),
   .normal_request_n_out(normal_request_n_out));
`default_nettype wire

// ==== verification/fsp_prio_model.sv ====
// Behavioural priority controller with one saved level
`timescale 1ns/1ps
`default_nettype none
module fsp_prio_model (
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rstn_in,
   // Bench raises one pending source
   input  wire logic        set_in,
   input  wire logic [4:0]  set_src_in,
   input  wire logic [31:0] set_vec_in,
   // From the block
   input  wire logic        push_stb_in,
   input  wire logic        push_spur_in,
   input  wire logic [4:0]  push_src_in,
   input  wire logic        pop_stb_in,
   // To the block
   output logic             pending_out,
   output logic [4:0]       src_out,
   output logic [31:0]      vec_out,
   output logic [4:0]       saved_out,
   output var int           push_cnt_out
);
   logic [4:0] cur; // Id in service
   // Pending source; acknowledge drops it
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pending_out <= 1'b0;
         src_out     <= '0;
         vec_out     <= '0;
      end else if (set_in) begin
         pending_out <= 1'b1;
         src_out     <= set_src_in;
         vec_out     <= set_vec_in;
      end else if (push_stb_in && !push_spur_in) begin
         pending_out <= 1'b0;
      end
   end
   // One-deep stack; spurious pushes not saved, a simplification
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cur          <= '0;
         saved_out    <= '0;
         push_cnt_out <= 0;
      end else if (push_stb_in) begin
         push_cnt_out <= push_cnt_out + 1;
         if (!push_spur_in) begin
            saved_out <= cur;
            cur       <= push_src_in;
         end
      end else if (pop_stb_in) begin
         cur <= saved_out;
      end
   end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the fast/protect/spurious controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk, rstn, psel, pen, pwr, pready, perr, perr_s;
   logic        fsrc, set, pend, push, spur, pop, fq_n, nq_n, wake;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, sv0, spu, v, setv, pvec;
   logic [4:0]  s, sets, psrc, pushs, saved;
   int          err_count, compares, seed, t, pcnt;
   logic [11:0] ra [7] = '{fsp_pkg::SMR0_OFS, fsp_pkg::SVR0_OFS,
      fsp_pkg::SPU_OFS, fsp_pkg::DCR_OFS, fsp_pkg::IMR_OFS,
      fsp_pkg::ISR_OFS, fsp_pkg::FVR_OFS};
   fsp_ctrl dut_u (.ref_clk_in(clk), .rstn_in(rstn), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .pready_out(pready), .pslverr_out(perr),
      .prdata_out(prdata), .fast_src_in(fsrc), .prio_irq_in(pend),
      .prio_pending_in(pend), .prio_src_in(psrc), .prio_vector_in(pvec),
      .pop_src_in(saved), .push_stb_out(push), .push_spur_out(spur),
      .push_src_out(pushs), .pop_stb_out(pop), .fast_request_n_out(fq_n),
      .normal_request_n_out(nq_n), .wake_out(wake));
   fsp_prio_model prio_u (.ref_clk_in(clk), .rstn_in(rstn), .set_in(set),
      .set_src_in(sets), .set_vec_in(setv), .push_stb_in(push),
      .push_spur_in(spur), .push_src_in(pushs), .pop_stb_in(pop),
      .pending_out(pend), .src_out(psrc), .vec_out(pvec),
      .saved_out(saved), .push_cnt_out(pcnt));
   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Fast request after a vector read: edge codes release it
   function automatic logic fq_after_fvr(input int tc);
      fq_after_fvr = tc[0];
   endfunction
   // Verdict and end of run
   task automatic stop_test();
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 16) begin
            chk("pready", 1, pready);
            stop_test();
         end
         @(posedge clk);
      end
      rd = prdata;
      perr_s = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // Bounded wait for the fast request level
   task automatic wq(input logic x);
      int n;
      n = 0;
      while (fq_n !== x && n < 16) begin
         @(posedge clk);
         n++;
      end
      chk("fast_req_n", x, fq_n);
      if (fq_n !== x) stop_test();
   endtask
   // Partner gets a pending source
   task automatic raise();
      s = 5'($random(seed)) | 5'h01;
      v = $random(seed);
      @(posedge clk);
      set <= 1'b1;
      sets <= s;
      setv <= v;
      @(posedge clk);
      set <= 1'b0;
   endtask
   // Main sequence
   initial begin
      seed = 98;
      err_count = 0;
      compares = 0;
      {psel, pen, pwr, paddr, pwdata, set, sets, setv, rstn} = '0;
      fsrc = 1'b1;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      foreach (ra[i]) begin
         apb(0, ra[i], 0);
         chk("reset", 0, rd);
         chk("slverr", 0, perr_s);
      end
      chk("wake", 0, wake);
      sv0 = $random(seed);
      spu = $random(seed);
      apb(1, fsp_pkg::SVR0_OFS, sv0);
      apb(1, fsp_pkg::SPU_OFS, spu);
      for (t = 0; t < 3; t++) begin
         apb(1, t == 1 ? fsp_pkg::IDCR_OFS : fsp_pkg::IECR_OFS, 1);
         apb(0, fsp_pkg::IMR_OFS, 0);
         chk("imr", t != 1, rd);
      end
      // Every trigger code, each with its own active level
      for (t = 0; t < 4; t++) begin
         v = {25'h0, t[1:0], 2'b00, 3'($random(seed))};
         apb(1, fsp_pkg::SMR0_OFS, v);
         fsrc <= ~t[1];
         apb(0, fsp_pkg::SMR0_OFS, 0);
         chk("smr0", v, rd);
         repeat (6) @(posedge clk);
         apb(0, fsp_pkg::FVR_OFS, 0);
         chk("fvr idle", spu, rd);
         wq(1'b1);
         fsrc <= t[1];
         wq(1'b0);
         apb(0, fsp_pkg::FVR_OFS, 0);
         chk("fvr", sv0, rd);
         repeat (3) @(posedge clk);
         chk("fast_req_n", fq_after_fvr(t), fq_n);
         fsrc <= ~t[1];
         wq(1'b1);
      end
      // General mask over both lines, wake kept
      raise();
      fsrc <= 1'b1;
      wq(1'b0);
      apb(1, fsp_pkg::DCR_OFS, 2);
      repeat (2) @(posedge clk);
      chk("fast_req_n", 1, fq_n);
      chk("norm_req_n", 1, nq_n);
      chk("wake", 1, wake);
      apb(1, fsp_pkg::DCR_OFS, 0);
      wq(1'b0);
      chk("norm_req_n", 0, nq_n);
      apb(0, fsp_pkg::FVR_OFS, 0);
      wq(1'b1);
      // Normal mode vector reads, spurious, write, end of service
      apb(0, fsp_pkg::IVR_OFS, 0);
      chk("ivr", v, rd);
      apb(0, fsp_pkg::ISR_OFS, 0);
      chk("isr", s, rd);
      chk("pushes", 1, pcnt);
      apb(0, fsp_pkg::IVR_OFS, 0);
      chk("ivr spur", spu, rd);
      apb(1, fsp_pkg::IVR_OFS, $random(seed));
      chk("pushes", 2, pcnt);
      apb(1, fsp_pkg::EOICR_OFS, 0);
      apb(0, fsp_pkg::ISR_OFS, 0);
      chk("isr pop", 0, rd);
      // Protect mode: reads alone change nothing
      apb(1, fsp_pkg::DCR_OFS, 1);
      apb(0, fsp_pkg::DCR_OFS, 0);
      chk("dcr", 1, rd);
      raise();
      repeat (2) begin
         apb(0, fsp_pkg::IVR_OFS, 0);
         chk("ivr prot", v, rd);
      end
      apb(0, fsp_pkg::ISR_OFS, 0);
      chk("isr prot", 0, rd);
      chk("pushes", 2, pcnt);
      apb(1, fsp_pkg::IVR_OFS, $random(seed));
      apb(0, fsp_pkg::ISR_OFS, 0);
      chk("isr prot", s, rd);
      chk("pushes", 3, pcnt);
      apb(1, fsp_pkg::EOICR_OFS, 0);
      // Unmapped place is refused
      apb(0, 12'h13c, 0);
      chk("slverr", 1, perr_s);
      chk("unmapped", 0, rd);
      repeat (6) begin
         v = $random(seed);
         apb(1, fsp_pkg::SPU_OFS, v);
         apb(0, fsp_pkg::SPU_OFS, 0);
         chk("spu", v, rd);
      end
      stop_test();
   end
endmodule
`default_nettype wire
